// *** common/bmc_map.svh ***
// constants, offsets and timing counts of the battery measure block
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH

// clocks
`define BMC_REF_HZ 20000000
`define BMC_TB_HZ 32768
`define BMC_TB_DIV (`BMC_REF_HZ / `BMC_TB_HZ)

// measurement schedule, seconds
`define BMC_MEAS_PERIOD_S 4
`define BMC_TEMP_PERIOD_S 16
`define BMC_MEAS_TICKS (`BMC_MEAS_PERIOD_S * `BMC_TB_HZ)
`define BMC_TEMP_PER_MEAS (`BMC_TEMP_PERIOD_S / `BMC_MEAS_PERIOD_S)

// converter cycles, in time base periods, current cycle length given in ms
`define BMC_VT_TICKS 8192
`define BMC_CUR_MS 500
`define BMC_CUR_TICKS (`BMC_CUR_MS * `BMC_TB_HZ / 1000)

// result scaling
`define BMC_VOLT_SHIFT 2
`define BMC_TEMP_SHIFT 5
`define BMC_TEMP_OFFSET 40
`define BMC_TEMP_MAX 125
`define BMC_CUR_MAX 8191
`define BMC_CUR_MIN (-8192)

// reset values
`define BMC_MODE_RST 1'b1
`define BMC_CC_CNF_RST 16'h018B
`define BMC_VM_CNF_RST 12'h141
`define BMC_TAB_RST 8'h00

// estimator arithmetic
`define BMC_SOC_SHIFT 12
`define BMC_OCV_SHIFT_BASE 2
`define BMC_OCV_GAIN_HI 11
`define BMC_OCV_GAIN_LO 10

`endif

// *** common/bmc_pkg.sv ***
// types shared by the battery measure block
package bmc_pkg;
   typedef enum logic [1:0] {
      CH_CURRENT = 2'b00,
      CH_VOLTAGE = 2'b01,
      CH_TEMP = 2'b10
   } bmc_chan_e;

   typedef enum logic [1:0] {
      SQ_IDLE = 2'b00,
      SQ_ISSUE = 2'b01,
      SQ_WAIT = 2'b10
   } bmc_seq_e;

   typedef struct packed {
      logic valid;
      bmc_chan_e chan;
      logic [15:0] data;
   } bmc_result_s;

   typedef struct packed {
      logic wr;
      logic [15:0] data;
   } bmc_wr_s;
endpackage : bmc_pkg

// *** hw/bmc_conv.sv ***
// sigma-delta conversion counter for current, voltage and temperature
`timescale 1ns/100ps
`default_nettype none
`include "bmc_map.svh"

module bmc_conv
   import bmc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic start,
   input var bmc_chan_e chan,
   input wire logic adc_bit,
   output logic busy,
   output bmc_chan_e chan_q,
   output bmc_result_s result
);
   logic [14:0] cnt_q;
   logic [14:0] ones_q;
   logic [14:0] last_w;
   logic [14:0] ones_w;

   // -----------------------------------------------------------------
   // result scaling
   // -----------------------------------------------------------------
   function automatic logic [15:0] scale(bmc_chan_e c, logic [14:0] n);
      logic signed [16:0] v;
      v = 17'sd0;
      unique case (c)
         CH_CURRENT: begin
            v = $signed({2'b00, n}) + 17'(`BMC_CUR_MIN);
            if (v > 17'(`BMC_CUR_MAX)) v = 17'(`BMC_CUR_MAX);
         end
         CH_VOLTAGE: v = $signed({2'b00, n >> `BMC_VOLT_SHIFT});
         CH_TEMP: begin
            v = $signed({2'b00, n >> `BMC_TEMP_SHIFT})
               - 17'(`BMC_TEMP_OFFSET);
            if (v > 17'(`BMC_TEMP_MAX)) v = 17'(`BMC_TEMP_MAX);
         end
         default: v = 17'sd0;
      endcase
      return v[15:0];
   endfunction : scale

   assign last_w = (chan_q == CH_CURRENT) ? 15'(`BMC_CUR_TICKS - 1)
                                          : 15'(`BMC_VT_TICKS - 1);
   assign ones_w = ones_q + {14'h0000, adc_bit};

   // -----------------------------------------------------------------
   // cycle counter
   // -----------------------------------------------------------------
   // one conversion at a time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         chan_q <= CH_VOLTAGE;
         cnt_q <= 15'h0000;
         ones_q <= 15'h0000;
      end else if (ce) begin
         if (start && !busy) begin
            busy <= 1'b1;
            chan_q <= chan;
            cnt_q <= 15'h0000;
            ones_q <= 15'h0000;
         end else if (busy && tick) begin
            ones_q <= ones_w;
            cnt_q <= cnt_q + 15'h0001;
            if (cnt_q == last_w) busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result <= '0;
      end else if (ce) begin
         result.valid <= busy && tick && (cnt_q == last_w);
         result.chan <= chan_q;
         if (busy && tick && (cnt_q == last_w))
            result.data <= scale(chan_q, ones_w);
      end
   end
endmodule : bmc_conv
`default_nettype wire

// *** hw/bmc_sched.sv ***
// conversion slot scheduler for mixed and voltage-only modes
`timescale 1ns/100ps
`default_nettype none
`include "bmc_map.svh"

module bmc_sched
   import bmc_pkg::*;
#(
   parameter int unsigned MEAS_TICKS = `BMC_MEAS_TICKS
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic mode_volt,
   input wire logic conv_busy,
   output logic start,
   output bmc_chan_e chan,
   output logic volt_due
);
   localparam int W = $clog2(MEAS_TICKS);
   logic [W-1:0] meas_cnt_q;
   logic [1:0] temp_cnt_q;
   logic temp_due_q;
   logic wrap;
   logic go;
   bmc_seq_e st_q;

   assign wrap = tick && (meas_cnt_q == W'(MEAS_TICKS - 1));
   assign go = (st_q == SQ_IDLE)
      && (volt_due || temp_due_q || !mode_volt);

   // -----------------------------------------------------------------
   // 4 s and 16 s time marks
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meas_cnt_q <= '0;
         temp_cnt_q <= 2'b00;
      end else if (ce && tick) begin
         meas_cnt_q <= wrap ? '0 : meas_cnt_q + 1'b1;
         if (wrap)
            temp_cnt_q <= temp_cnt_q + 2'b01;
      end
   end

   // voltage every 4 s, temperature every 16 s
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         volt_due <= 1'b1;
         temp_due_q <= 1'b0;
      end else if (ce) begin
         if (wrap)
            volt_due <= 1'b1;
         else if (go && volt_due)
            volt_due <= 1'b0;
         if (wrap && temp_cnt_q == 2'(`BMC_TEMP_PER_MEAS - 1))
            temp_due_q <= 1'b1;
         else if (go && !volt_due && temp_due_q)
            temp_due_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // slot issue
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= SQ_IDLE;
         start <= 1'b0;
         chan <= CH_VOLTAGE;
      end else if (ce) begin
         start <= 1'b0;
         unique case (st_q)
            SQ_IDLE: begin
               if (go) begin
                  st_q <= SQ_ISSUE;
                  start <= 1'b1;
                  if (volt_due)
                     chan <= CH_VOLTAGE;
                  else if (temp_due_q)
                     chan <= CH_TEMP;
                  // no current slots in voltage-only mode
                  else
                     chan <= CH_CURRENT;
               end
            end
            SQ_ISSUE: st_q <= SQ_WAIT;
            SQ_WAIT: if (!conv_busy) st_q <= SQ_IDLE;
            default: st_q <= SQ_IDLE;
         endcase
      end
   end
endmodule : bmc_sched
`default_nettype wire

// *** hw/bmc_gauge.sv ***
// battery measurement sequencer and charge accumulator, top level
`timescale 1ns/100ps
`default_nettype none
`include "bmc_map.svh"

module bmc_gauge
   import bmc_pkg::*;
#(
   parameter int unsigned MEAS_TICKS = `BMC_MEAS_TICKS,
   parameter int unsigned TB_DIV = `BMC_TB_DIV,
   parameter int unsigned TAB_DEPTH = 16,
   parameter int unsigned TAB_W = 8
)
(
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic ADC_BIT,
   input wire logic MODE_WR,
   input wire logic MODE_WDATA,
   input wire logic SOC_WR,
   input wire logic [15:0] SOC_WDATA,
   input wire logic CC_CNF_WR,
   input wire logic [15:0] CC_CNF_WDATA,
   input wire logic VM_CNF_WR,
   input wire logic [11:0] VM_CNF_WDATA,
   input wire logic TAB_WR,
   input wire logic [$clog2(TAB_DEPTH)-1:0] TAB_IDX,
   input wire logic [TAB_W-1:0] TAB_WDATA,
   output logic CONV_MODE_SELECT,
   output logic ADC_RUN,
   output logic [1:0] ADC_CHAN,
   output logic [11:0] VOLTAGE,
   output logic [7:0] TEMPERATURE,
   output logic [13:0] CURRENT,
   output logic [31:0] CHARGE_ACC,
   output logic [15:0] CONV_COUNT,
   output logic [15:0] SOC,
   output logic [15:0] CHARGE_SCALE_CONFIG,
   output logic [11:0] VOLTAGE_MODEL_CONFIG,
   output logic [11:0] OPEN_CIRCUIT_ESTIMATE,
   output logic [TAB_W-1:0] TAB_RDATA
);
   localparam int DW = $clog2(TB_DIV);

   // -----------------------------------------------------------------
   // reset release and time base
   // -----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;
   logic [DW-1:0] div_q;
   logic tick_q;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (CLK_EN) begin
         tick_q <= (div_q == DW'(TB_DIV - 1));
         div_q <= (div_q == DW'(TB_DIV - 1)) ? '0 : div_q + 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // host control values
   // -----------------------------------------------------------------
   bmc_wr_s soc_wr;
   logic mode_q;
   logic [15:0] cc_cnf_q;
   logic [11:0] vm_cnf_q;

   assign soc_wr.wr = SOC_WR;
   assign soc_wr.data = SOC_WDATA;

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         mode_q <= `BMC_MODE_RST;
      // mode may change at any time
      else if (CLK_EN && MODE_WR)
         mode_q <= MODE_WDATA;
   end

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         cc_cnf_q <= `BMC_CC_CNF_RST;
      else if (CLK_EN && CC_CNF_WR)
         cc_cnf_q <= CC_CNF_WDATA;
   end

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         vm_cnf_q <= `BMC_VM_CNF_RST;
      else if (CLK_EN && VM_CNF_WR)
         vm_cnf_q <= VM_CNF_WDATA;
   end

   // -----------------------------------------------------------------
   // rest voltage curve table
   // -----------------------------------------------------------------
   logic [TAB_W-1:0] tab_q [TAB_DEPTH];
   logic [TAB_W-1:0] tab_rd_q;

   for (genvar i = 0; i < TAB_DEPTH; i++) begin : g_tab
      always_ff @(posedge REF_CLK or negedge rst_n_q) begin
         if (!rst_n_q)
            tab_q[i] <= `BMC_TAB_RST;
         else if (CLK_EN && TAB_WR && TAB_IDX == i)
            tab_q[i] <= TAB_WDATA;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         tab_rd_q <= `BMC_TAB_RST;
      else if (CLK_EN)
         tab_rd_q <= tab_q[TAB_IDX];
   end

   // -----------------------------------------------------------------
   // scheduler and converter
   // -----------------------------------------------------------------
   logic conv_start;
   logic conv_busy;
   logic volt_due;
   bmc_chan_e sched_chan;
   bmc_chan_e conv_chan;
   bmc_result_s res;

   bmc_sched #(
      .MEAS_TICKS(MEAS_TICKS)
   ) u_sched (
      .clk(REF_CLK),
      .rst_n(rst_n_q),
      .ce(CLK_EN),
      .tick(tick_q),
      .mode_volt(mode_q),
      .conv_busy(conv_busy),
      .start(conv_start),
      .chan(sched_chan),
      .volt_due(volt_due)
   );

   bmc_conv u_conv (
      .clk(REF_CLK),
      .rst_n(rst_n_q),
      .ce(CLK_EN),
      .tick(tick_q),
      .start(conv_start),
      .chan(sched_chan),
      .adc_bit(ADC_BIT),
      .busy(conv_busy),
      .chan_q(conv_chan),
      .result(res)
   );

   logic adc_run_q;
   logic [1:0] adc_chan_q;

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         adc_run_q <= 1'b0;
         adc_chan_q <= CH_VOLTAGE;
      end else if (CLK_EN) begin
         adc_run_q <= conv_busy;
         adc_chan_q <= conv_chan;
      end
   end

   // -----------------------------------------------------------------
   // result registers
   // -----------------------------------------------------------------
   logic cur_done;
   logic [11:0] volt_q;
   logic [7:0] temp_q;
   logic [13:0] cur_q;

   assign cur_done = res.valid && res.chan == CH_CURRENT;

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         volt_q <= '0;
      else if (CLK_EN && res.valid && res.chan == CH_VOLTAGE)
         volt_q <= res.data[11:0];
   end

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         temp_q <= '0;
      else if (CLK_EN && res.valid && res.chan == CH_TEMP)
         temp_q <= res.data[7:0];
   end

   // load only before a voltage slot
   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         cur_q <= '0;
      else if (CLK_EN && cur_done && volt_due)
         cur_q <= res.data[13:0];
   end

   // -----------------------------------------------------------------
   // charge counting
   // -----------------------------------------------------------------
   logic count_en;
   logic [31:0] acc_q;
   logic [15:0] cnt_q;
   logic [31:0] soc_frac_q;
   logic signed [32:0] prod;

   assign count_en = cur_done && !mode_q;
   assign prod = $signed(res.data) * $signed({1'b0, cc_cnf_q});

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         acc_q <= '0;
         cnt_q <= '0;
      end else if (CLK_EN) begin
         if (soc_wr.wr) begin
            acc_q <= '0;
            cnt_q <= '0;
         end else if (count_en) begin
            acc_q <= acc_q + 32'($signed(res.data));
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q)
         soc_frac_q <= '0;
      else if (CLK_EN && soc_wr.wr)
         soc_frac_q <= 32'({soc_wr.data, `BMC_SOC_SHIFT'(0)});
      // state held, not cleared, across mode changes
      else if (CLK_EN && count_en)
         soc_frac_q <= soc_frac_q + 32'(prod);
   end

   // -----------------------------------------------------------------
   // open circuit voltage estimator
   // -----------------------------------------------------------------
   logic ocv_init_q;
   logic [11:0] ocv_q;
   logic signed [12:0] ocv_diff;
   logic signed [12:0] ocv_step;
   logic [2:0] ocv_shift;

   assign ocv_shift = 3'(`BMC_OCV_SHIFT_BASE)
      + {1'b0, vm_cnf_q[`BMC_OCV_GAIN_HI:`BMC_OCV_GAIN_LO]};
   assign ocv_diff = $signed({1'b0, res.data[11:0]})
      - $signed({1'b0, ocv_q});
   assign ocv_step = ocv_diff >>> ocv_shift;

   always_ff @(posedge REF_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ocv_init_q <= 1'b0;
         ocv_q <= '0;
      end else if (CLK_EN && res.valid && res.chan == CH_VOLTAGE) begin
         ocv_init_q <= 1'b1;
         ocv_q <= ocv_init_q ? ocv_q + ocv_step[11:0] : res.data[11:0];
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // values exposed as plain register ports
   assign CONV_MODE_SELECT = mode_q;
   assign ADC_RUN = adc_run_q;
   assign ADC_CHAN = adc_chan_q;
   assign VOLTAGE = volt_q;
   assign TEMPERATURE = temp_q;
   assign CURRENT = cur_q;
   assign CHARGE_ACC = acc_q;
   assign CONV_COUNT = cnt_q;
   assign SOC = soc_frac_q[`BMC_SOC_SHIFT+15:`BMC_SOC_SHIFT];
   assign CHARGE_SCALE_CONFIG = cc_cnf_q;
   assign VOLTAGE_MODEL_CONFIG = vm_cnf_q;
   assign OPEN_CIRCUIT_ESTIMATE = ocv_q;
   assign TAB_RDATA = tab_rd_q;
endmodule : bmc_gauge
`default_nettype wire

// *** bench/bmc_modulator_model.sv ***
// modulator bit source standing in for the analog front end
`timescale 1ns/100ps
`default_nettype none

module bmc_modulator_model
   import bmc_pkg::*;
(
   input wire logic [1:0] chan,
   output logic bit_out
);
   // ----------------------------------------
   // full scale on voltage and current, zero on temperature
   // ----------------------------------------
   // case inequality keeps the bit defined even before reset settles
   assign bit_out = (chan !== CH_TEMP);
endmodule : bmc_modulator_model

`default_nettype wire

// *** bench/bmc_gauge_assertions.sv ***
// concurrent checks on the battery measure top level ports
`timescale 1ns/100ps
`default_nettype none

module bmc_gauge_assertions
   import bmc_pkg::*;
#(
   parameter int unsigned TB_DIV = 2,
   parameter int unsigned TAB_DEPTH = 16,
   parameter int unsigned TAB_W = 8
)
(
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic MODE_WR,
   input wire logic MODE_WDATA,
   input wire logic SOC_WR,
   input wire logic [15:0] SOC_WDATA,
   input wire logic CC_CNF_WR,
   input wire logic [15:0] CC_CNF_WDATA,
   input wire logic TAB_WR,
   input wire logic [$clog2(TAB_DEPTH)-1:0] TAB_IDX,
   input wire logic [TAB_W-1:0] TAB_WDATA,
   input wire logic CONV_MODE_SELECT,
   input wire logic ADC_RUN,
   input wire logic [1:0] ADC_CHAN,
   input wire logic [11:0] VOLTAGE,
   input wire logic [7:0] TEMPERATURE,
   input wire logic [31:0] CHARGE_ACC,
   input wire logic [15:0] CONV_COUNT,
   input wire logic [15:0] SOC,
   input wire logic [15:0] CHARGE_SCALE_CONFIG,
   input wire logic [TAB_W-1:0] TAB_RDATA
);
   localparam int VT_LEN = 8192 * TB_DIV;
   localparam int CUR_LEN = 16384 * TB_DIV;
   localparam int TOL = TB_DIV + 3;
   logic [31:0] run_len_q;

   default clocking dc @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   // ----------------------------------------
   // run length counter
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_len_q <= '0;
      end else if (CLK_EN) begin
         run_len_q <= ADC_RUN ? run_len_q + 32'h0000_0001 : '0;
      end
   end

   sequence tab_store_s;
      TAB_WR && CLK_EN ##1 CLK_EN && !TAB_WR && $stable(TAB_IDX);
   endsequence

   // ----------------------------------------
   // properties
   // ----------------------------------------
   // mode resets high
   mode_reset_a: assert property ($rose(RESET_N) |-> CONV_MODE_SELECT)
      else $error("mode bit not set out of reset");
   mode_write_a: assert property (
      MODE_WR && CLK_EN |=> CONV_MODE_SELECT == $past(MODE_WDATA))
      else $error("mode bit did not take written value");
   volt_nocur_a: assert property (
      $rose(ADC_RUN) && $past(CONV_MODE_SELECT, 2)
      && $past(CONV_MODE_SELECT, 3) |-> ADC_CHAN != 2'b00)
      else $error("current conversion started in voltage mode");
   soc_restart_a: assert property (SOC_WR && CLK_EN |=>
      SOC == $past(SOC_WDATA) && CHARGE_ACC == 32'h0000_0000
      && CONV_COUNT == 16'h0000)
      else $error("charge state write did not restart counting");
   count_step_a: assert property (
      $changed(CONV_COUNT) && !$past(SOC_WR) |->
      CONV_COUNT == $past(CONV_COUNT) + 16'h0001 && $past(ADC_CHAN) == 2'b00)
      else $error("conversion count moved without a current result");
   vt_length_a: assert property (
      $fell(ADC_RUN) && ADC_CHAN != 2'b00 |->
      run_len_q >= VT_LEN - TOL && run_len_q <= VT_LEN + TOL)
      else $error("voltage or temperature cycle length wrong");
   cur_length_a: assert property (
      $fell(ADC_RUN) && ADC_CHAN == 2'b00 |->
      run_len_q >= CUR_LEN - TOL && run_len_q <= CUR_LEN + TOL)
      else $error("current cycle length wrong");
   scale_write_a: assert property (
      CC_CNF_WR && CLK_EN |=> CHARGE_SCALE_CONFIG == $past(CC_CNF_WDATA))
      else $error("charge scale config did not take written value");
   tab_read_a: assert property (
      tab_store_s ##1 CLK_EN |-> TAB_RDATA == $past(TAB_WDATA, 2))
      else $error("curve table readback wrong");
   temp_range_a: assert property ($signed(TEMPERATURE) >= -8'sd40
      && $signed(TEMPERATURE) <= 8'sd125)
      else $error("temperature outside span");
   volt_range_a: assert property (VOLTAGE <= 12'h800)
      else $error("voltage above full scale");
endmodule : bmc_gauge_assertions

bind bmc_gauge bmc_gauge_assertions #(
   .TB_DIV(TB_DIV), .TAB_DEPTH(TAB_DEPTH), .TAB_W(TAB_W)
) u_checks (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
   .MODE_WR(MODE_WR), .MODE_WDATA(MODE_WDATA), .SOC_WR(SOC_WR),
   .SOC_WDATA(SOC_WDATA), .CC_CNF_WR(CC_CNF_WR),
   .CC_CNF_WDATA(CC_CNF_WDATA), .TAB_WR(TAB_WR), .TAB_IDX(TAB_IDX),
   .TAB_WDATA(TAB_WDATA), .CONV_MODE_SELECT(CONV_MODE_SELECT),
   .ADC_RUN(ADC_RUN), .ADC_CHAN(ADC_CHAN), .VOLTAGE(VOLTAGE),
   .TEMPERATURE(TEMPERATURE), .CHARGE_ACC(CHARGE_ACC),
   .CONV_COUNT(CONV_COUNT), .SOC(SOC),
   .CHARGE_SCALE_CONFIG(CHARGE_SCALE_CONFIG), .TAB_RDATA(TAB_RDATA)
);

`default_nettype wire

// *** bench/bmc_gauge_bench.sv ***
// self-checking bench for the battery measure top level
`timescale 1ns/100ps
`default_nettype none

module bmc_gauge_bench
   import bmc_pkg::*;
;
   localparam int unsigned TB_DIV = 2;
   localparam logic [4:0] W_MODE = 5'h10;
   localparam logic [4:0] W_SOC = 5'h08;
   localparam logic [4:0] W_CC = 5'h04;
   localparam logic [4:0] W_VM = 5'h02;
   localparam logic [4:0] W_TAB = 5'h01;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic adc_bit;
   logic [4:0] wr_q = 5'h00;
   logic [15:0] wdata = 16'h0001;
   logic [3:0] tab_idx = 4'h0;
   logic conv_mode_select;
   logic adc_run;
   logic [1:0] adc_chan;
   logic [11:0] voltage;
   logic [7:0] temperature;
   logic [13:0] current;
   logic [31:0] charge_acc;
   logic [15:0] conv_count;
   logic [15:0] soc;
   logic [15:0] cc_cfg;
   logic [11:0] vm_cfg;
   logic [11:0] ocv;
   logic [7:0] tab_rdata;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   bmc_gauge #(.MEAS_TICKS(40000), .TB_DIV(TB_DIV)) DUT (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
      .ADC_BIT(adc_bit), .MODE_WR(wr_q[4]), .MODE_WDATA(wdata[0]),
      .SOC_WR(wr_q[3]), .SOC_WDATA(wdata), .CC_CNF_WR(wr_q[2]),
      .CC_CNF_WDATA(wdata), .VM_CNF_WR(wr_q[1]),
      .VM_CNF_WDATA(wdata[11:0]), .TAB_WR(wr_q[0]), .TAB_IDX(tab_idx),
      .TAB_WDATA(wdata[7:0]), .CONV_MODE_SELECT(conv_mode_select),
      .ADC_RUN(adc_run), .ADC_CHAN(adc_chan), .VOLTAGE(voltage),
      .TEMPERATURE(temperature), .CURRENT(current),
      .CHARGE_ACC(charge_acc), .CONV_COUNT(conv_count), .SOC(soc),
      .CHARGE_SCALE_CONFIG(cc_cfg), .VOLTAGE_MODEL_CONFIG(vm_cfg),
      .OPEN_CIRCUIT_ESTIMATE(ocv), .TAB_RDATA(tab_rdata)
   );

   bmc_modulator_model MOD (.chan(adc_chan), .bit_out(adc_bit));

   // ----------------------------------------
   // clock, watchdog and tasks
   // ----------------------------------------
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 100000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // one-cycle write strobe, result visible after the following edge
   task automatic wr(input logic [4:0] sel, input logic [15:0] d);
      @(posedge ref_clk);
      #5;
      wr_q = sel;
      wdata = d;
      @(posedge ref_clk);
      #5;
      wr_q = 5'h00;
      @(posedge ref_clk);
      #5;
   endtask : wr

   task automatic wait_end(input logic [1:0] ch);
      while (!(adc_run === 1'b1 && adc_chan === ch)) @(posedge ref_clk);
      while (adc_run !== 1'b0) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
      #5;
   endtask : wait_end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      #5;
      reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      #5;
      cmp("mode", 32'h0000_0001, conv_mode_select);
      cmp("cc_cfg", 32'h0000_018B, cc_cfg);
      cmp("vm_cfg", 32'h0000_0141, vm_cfg);
      cmp("acc", 32'h0000_0000, charge_acc);
      cmp("temp", 32'h0000_0000, temperature);
      clk_en = 1'b0;
      wr(W_CC, 16'h0099);
      clk_en = 1'b1;
      cmp("cc_frozen", 32'h0000_018B, cc_cfg);
      wr(W_CC, 16'h014D);
      cmp("cc_cfg", 32'h0000_014D, cc_cfg);
      wr(W_VM, 16'h00A9);
      cmp("vm_cfg", 32'h0000_00A9, vm_cfg);
      for (int i = 0; i < 16; i++) begin
         tab_idx = i[3:0];
         wr(W_TAB, 16'h0011 * i[15:0]);
      end
      for (int i = 0; i < 16; i++) begin
         tab_idx = i[3:0];
         repeat (2) @(posedge ref_clk);
         #5;
         cmp("tab", {24'h00_0000, 8'h11 * i[7:0]}, tab_rdata);
      end
      wr(W_SOC, 16'h3200);
      cmp("soc", 32'h0000_3200, soc);
      wait_end(2'b01);
      cmp("voltage", 32'h0000_0800, voltage);
      cmp("ocv", 32'h0000_0800, ocv);
      cmp("count_idle", 32'h0000_0000, conv_count);
      wr(W_MODE, 16'h0000);
      cmp("mode", 32'h0000_0000, conv_mode_select);
      wait_end(2'b00);
      cmp("count", 32'h0000_0001, conv_count);
      cmp("acc", 32'h0000_1FFF, charge_acc);
      // not next to a voltage slot, so the current register keeps zero
      cmp("current", 32'h0000_0000, current);
      // 0x3200 plus 8191 * 333 / 4096
      cmp("soc_acc", 32'h0000_3499, soc);
      wr(W_MODE, 16'h0001);
      wr(W_SOC, 16'h1000);
      cmp("soc", 32'h0000_1000, soc);
      cmp("acc", 32'h0000_0000, charge_acc);
      cmp("count", 32'h0000_0000, conv_count);
      complete_run();
   end
endmodule : bmc_gauge_bench

`default_nettype wire
